// File: rtl/e1tbi_top.sv
`timescale 1ns/1ps
`default_nettype none

module e1tbi_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  // Capacity is DEPTH words in the array plus one in the output register.
  // A push into a full array is refused; the producer sees o_ready low.

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } e1tbi_fifo_st_t;

  e1tbi_fifo_st_t q;
  e1tbi_fifo_st_t n;
  logic           push;
  logic           pop;

  always_comb begin
    n    = q;
    push = i_valid && (q.cnt != FULL);
    pop  = (q.cnt != '0) && (!q.ov || i_ready);
    // Output stage is a register so the consumer sees flop outputs
    if (!q.ov || i_ready) begin
      n.ov = pop;
    end
    if (pop) begin
      n.od = q.mem[q.rp];
      n.rp = q.rp + 1'b1;
    end
    if (push) begin
      n.mem[q.wp] = i_data;
      n.wp        = q.wp + 1'b1;
    end
    n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else if (i_ce) begin
      q <= n;
    end
  end

  assign o_ready = (q.cnt != FULL);
  assign o_valid = q.ov;
  assign o_data  = q.od;
endmodule

module e1tbi_top (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_ce,
  input  wire e1tbi_pkg::e1tbi_bus_t i_bus,
  output logic [31:0]                o_rdata,
  input  wire logic                  i_serial_clock,
  output logic                       o_serial_clock,
  output logic                       o_serial_clock_oe,
  input  wire logic                  i_channel_clock,
  input  wire logic                  i_frame_sync,
  input  wire logic                  i_superframe_sync,
  input  wire logic                  i_serial_data,
  input  wire logic [4:0]            i_tsi,
  output logic [4:0]                 o_tsi,
  output logic [4:0]                 o_tsi_oe,
  output e1tbi_pkg::e1tbi_word_t     o_word,
  output logic                       o_word_valid,
  input  wire logic                  i_word_ready
);
  typedef struct packed {
    e1tbi_pkg::e1tbi_link_t s1;
    e1tbi_pkg::e1tbi_link_t s2;
    e1tbi_pkg::e1tbi_link_t s3;
    e1tbi_pkg::e1tbi_link_t filt;
    e1tbi_pkg::e1tbi_link_t filt_d;
    logic [7:0]             ctrl;
    logic                   drive;
    logic                   ovf;
    logic [31:0]            rdata;
    logic [15:0]            nco;
    logic [15:0]            nco_hs;
    logic                   int_clk;
    logic                   hs_clk;
    logic [9:0]             bit_cnt;
    logic [3:0]             frame;
    logic [3:0][7:0]        sh;
    logic [7:0]             frac_sh;
    logic [2:0]             frac_cnt;
    logic                   frac_pend;
    logic [7:0]             frac_byte;
    logic                   ovh;
    logic                   gap;
    logic                   push;
    e1tbi_pkg::e1tbi_word_t push_word;
    logic                   ser_clk_o;
    logic                   ser_oe;
    logic [4:0]             tsi_o;
    logic [4:0]             tsi_oe;
  } e1tbi_st_t;

  // Filtered link lines, the control shadow, the bit and frame counters,
  // the per-channel shift registers and the registered pin values all live
  // in this one state word.

  e1tbi_st_t              q;
  e1tbi_st_t              n;
  e1tbi_pkg::e1tbi_link_t link_raw;
  logic                   fifo_ready;
  logic                   base;
  logic                   mux;
  logic                   frac_eff;
  logic                   inv_eff;
  logic                   sig_eff;
  logic [16:0]            sum;
  logic [16:0]            sum_hs;
  logic                   carry;
  logic                   rise;
  logic                   fall;
  logic                   sample;
  logic                   fedge;
  logic [9:0]             cur;
  logic [3:0]             fr;
  logic [1:0]             chan;
  logic [2:0]             pos;
  logic [4:0]             slot;
  logic [4:0]             next_slot;
  logic [7:0]             byte_in;
  logic [9:0]             last_bit;

  assign link_raw = '{serial_clock:    i_serial_clock,
                      channel_clock:   i_channel_clock,
                      frame_sync:      i_frame_sync,
                      superframe_sync: i_superframe_sync,
                      serial_data:     i_serial_data,
                      signalling:      i_tsi[0],
                      fractional:      i_tsi[1]};

  always_comb begin
    n         = q;
    // Three-stage synchroniser; a high is accepted once stages two and three agree high, a disagreement forces a low, two lows hold the filtered value
    n.s1      = link_raw;
    n.s2      = q.s1;
    n.s3      = q.s2;
    n.filt    = e1tbi_pkg::e1tbi_link_t'((q.s2 & q.s3) | (q.filt & ~(q.s2 ^ q.s3)));
    n.filt_d  = q.filt;

    mux       = q.ctrl[e1tbi_pkg::BIT_MUX];
    base      = !mux && (q.ctrl[1:0] == e1tbi_pkg::SPEED_BASE);
    frac_eff  = q.ctrl[e1tbi_pkg::BIT_FRAC] && base;
    inv_eff   = q.ctrl[e1tbi_pkg::BIT_INV] && base;
    sig_eff   = frac_eff || !base;

    // Internal 2.048MHz bit clock and 32MHz auxiliary clock
    sum       = {1'b0, q.nco} + {1'b0, e1tbi_pkg::SERCLK_INC};
    carry     = sum[16];
    n.nco     = sum[15:0];
    if (carry) begin
      n.int_clk = !q.int_clk;
    end
    sum_hs    = {1'b0, q.nco_hs} + {1'b0, e1tbi_pkg::HSCLK_INC};
    n.nco_hs  = sum_hs[15:0];
    if (sum_hs[16]) begin
      n.hs_clk = !q.hs_clk;
    end

    if (q.drive) begin
      rise = carry && !q.int_clk;
      fall = carry && q.int_clk;
    end else begin
      rise = q.filt.serial_clock && !q.filt_d.serial_clock;
      fall = !q.filt.serial_clock && q.filt_d.serial_clock;
    end
    // Sample on the edge opposite to the one on which data changes
    sample    = inv_eff ? rise : fall;

    // Sync inputs realign the counters to bit 0 of a frame / superframe
    cur       = q.filt.frame_sync || q.filt.superframe_sync ? '0 : q.bit_cnt;
    fr        = q.filt.superframe_sync ? '0 : q.frame;
    chan      = mux ? cur[1:0] : 2'h0;
    pos       = mux ? cur[4:2] : cur[2:0];
    slot      = mux ? cur[9:5] : cur[7:3];
    last_bit  = mux ? e1tbi_pkg::LAST_BIT_MUX : e1tbi_pkg::LAST_BIT_BASE;
    byte_in   = {q.sh[chan][6:0], q.filt.serial_data};

    // A completed fractional byte waits one cycle when a data word takes the
    // push slot, so neither word is lost.

    n.push    = 1'b0;
    if (q.frac_pend) begin
      n.push      = 1'b1;
      n.frac_pend = 1'b0;
      n.push_word = '{sig: 1'b0, frac: 1'b1, chan: 2'h0,
                      slot: q.bit_cnt[7:3], data: q.frac_byte};
    end

    if (sample) begin
      n.sh[chan] = byte_in;
      if (pos == e1tbi_pkg::LAST_BIT_POS) begin
        n.push      = 1'b1;
        n.push_word = '{sig: q.filt.signalling && sig_eff, frac: 1'b0, chan: chan,
                        slot: slot, data: byte_in};
        if (q.frac_pend) begin
          n.frac_pend = 1'b1;
        end
      end
      if (cur == last_bit) begin
        n.bit_cnt = '0;
        n.frame   = (fr == e1tbi_pkg::LAST_FRAME) ? 4'h0 : fr + 4'h1;
      end else begin
        n.bit_cnt = cur + 10'h001;
        n.frame   = fr;
      end
      n.ovh = frac_eff && (cur == '0) && (fr == '0);
    end

    // Fractional input capture
    if (q.ctrl[e1tbi_pkg::BIT_SYNC_FRAC]) begin
      fedge = sample && q.filt.channel_clock;
    end else begin
      fedge = q.filt.channel_clock && !q.filt_d.channel_clock;
    end
    if (frac_eff && fedge) begin
      n.frac_sh  = {q.frac_sh[6:0], q.filt.fractional};
      n.frac_cnt = q.frac_cnt + 3'h1;
      if (q.frac_cnt == e1tbi_pkg::LAST_BIT_POS) begin
        n.frac_pend = 1'b1;
        n.frac_byte = {q.frac_sh[6:0], q.filt.fractional};
      end
    end

    // Overflow sets in the cycle a word is refused; set beats a clear
    if (i_bus.wr && (i_bus.addr == e1tbi_pkg::REG_STATUS) && i_bus.wdata[e1tbi_pkg::STAT_OVF_BIT]) begin
      n.ovf = 1'b0;
    end
    if (q.push && !fifo_ready) begin
      n.ovf = 1'b1;
    end

    // Serial clock pin: bit counter indexes the next bit, slot 0 is overhead
    next_slot = mux ? q.bit_cnt[9:5] : q.bit_cnt[7:3];
    n.gap     = q.ctrl[e1tbi_pkg::BIT_PLCLK] && (next_slot == 5'h00);
    // The pin only goes high on a true rising edge of the internal clock, so
    // enabling the drive mid-phase never produces a shortened high phase.
    // While the drive is off the pin value is held low.
    n.ser_clk_o = q.drive && n.int_clk && !n.gap && (q.ser_clk_o || rise);
    n.ser_oe    = q.drive;

    // Time-slot identifier pins
    // Pins 0 and 1 become inputs in fractional mode; pin 0 stays an input
    // whenever the interface is not at base rate.

    n.tsi_o  = next_slot;
    n.tsi_oe = e1tbi_pkg::TSI_OE_ALL;
    if (frac_eff) begin
      n.tsi_o[2] = n.hs_clk;
      n.tsi_o[3] = n.ovh;
      n.tsi_oe   = e1tbi_pkg::TSI_OE_FRAC;
    end else if (!base) begin
      n.tsi_oe   = e1tbi_pkg::TSI_OE_HS;
    end

    // Register writes

    if (i_bus.wr) begin
      case (i_bus.addr)
        e1tbi_pkg::REG_CTRL: begin
          n.ctrl = i_bus.wdata[7:0] & e1tbi_pkg::CTRL_WMASK;
        end
        e1tbi_pkg::REG_CFG: begin
          n.drive = i_bus.wdata[e1tbi_pkg::BIT_DRIVE];
        end
        default: begin
        end
      endcase
    end

    // Register reads, data valid in the following cycle only
    n.rdata = '0;
    if (i_bus.rd) begin
      case (i_bus.addr)
        e1tbi_pkg::REG_CTRL: begin
          n.rdata[7:0] = q.ctrl;
        end
        e1tbi_pkg::REG_CFG: begin
          n.rdata[e1tbi_pkg::BIT_DRIVE] = q.drive;
        end
        e1tbi_pkg::REG_STATUS: begin
          n.rdata[4:0]                     = next_slot;
          n.rdata[8:5]                     = q.frame;
          n.rdata[e1tbi_pkg::STAT_OVF_BIT] = q.ovf;
        end
        default: begin
        end
      endcase
    end
  end

  // Reset wins over the clock enable so a frozen block can still be reset

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q       <= '0;
      q.ctrl  <= e1tbi_pkg::CTRL_RESET;
      q.drive <= e1tbi_pkg::DRIVE_RESET;
      q.tsi_oe <= e1tbi_pkg::TSI_OE_ALL;
    end else if (i_ce) begin
      q <= n;
    end
  end

  e1tbi_fifo #(
    .W     ($bits(e1tbi_pkg::e1tbi_word_t)),
    .DEPTH (e1tbi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_valid (q.push),
    .o_ready (fifo_ready),
    .i_data  (q.push_word),
    .o_valid (o_word_valid),
    .i_ready (i_word_ready),
    .o_data  (o_word)
  );


  assign o_rdata           = q.rdata;
  assign o_serial_clock    = q.ser_clk_o;
  assign o_serial_clock_oe = q.ser_oe;
  assign o_tsi             = q.tsi_o;
  assign o_tsi_oe          = q.tsi_oe;
endmodule
`default_nettype wire

// File: shared/e1tbi_pkg.sv
`default_nettype none
package e1tbi_pkg;

  // Timing
  localparam int CLK_FREQ_KHZ       = 100000;
  localparam int SERCLK_FREQ_KHZ    = 2048;
  localparam int HSCLK_FREQ_KHZ     = 32000;
  localparam int FRAME_TIME_US      = 125;
  localparam int SUPERFRAME_TIME_US = 2000;
  localparam int NCO_W              = 16;
  localparam int NCO_SPAN           = 65536;
  // Phase increments per system clock; the NCO output toggles on each carry
  localparam logic [NCO_W-1:0] SERCLK_INC = NCO_W'((SERCLK_FREQ_KHZ * NCO_SPAN) / (CLK_FREQ_KHZ / 2));
  localparam logic [NCO_W-1:0] HSCLK_INC  = NCO_W'((HSCLK_FREQ_KHZ * NCO_SPAN) / (CLK_FREQ_KHZ / 2));
  localparam int BASE_FRAME_BITS    = (SERCLK_FREQ_KHZ * FRAME_TIME_US) / 1000;
  localparam int MUX_CHANNELS       = 4;
  localparam logic [9:0] LAST_BIT_BASE = 10'(BASE_FRAME_BITS - 1);
  localparam logic [9:0] LAST_BIT_MUX  = 10'(BASE_FRAME_BITS * MUX_CHANNELS - 1);
  localparam logic [3:0] LAST_FRAME    = 4'(SUPERFRAME_TIME_US / FRAME_TIME_US - 1);
  localparam logic [2:0] LAST_BIT_POS  = 3'h7;

  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CFG    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // tx_interface_control fields
  localparam int BIT_SYNC_FRAC = 7;
  localparam int BIT_PLCLK     = 5;
  localparam int BIT_FRAC      = 4;
  localparam int BIT_INV       = 3;
  localparam int BIT_MUX       = 2;
  localparam logic [1:0] SPEED_BASE = 2'h0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hbf;
  // Config and status fields
  localparam int BIT_DRIVE     = 0;
  localparam logic DRIVE_RESET = 1'b0;
  localparam int STAT_OVF_BIT  = 9;

  // Time-slot identifier pin enables
  localparam logic [4:0] TSI_OE_ALL  = 5'h1f;
  localparam logic [4:0] TSI_OE_FRAC = 5'h1c;
  localparam logic [4:0] TSI_OE_HS   = 5'h1e;

  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } e1tbi_bus_t;

  typedef struct packed {
    logic serial_clock;
    logic channel_clock;
    logic frame_sync;
    logic superframe_sync;
    logic serial_data;
    logic signalling;
    logic fractional;
  } e1tbi_link_t;

  typedef struct packed {
    logic       sig;
    logic       frac;
    logic [1:0] chan;
    logic [4:0] slot;
    logic [7:0] data;
  } e1tbi_word_t;

endpackage
`default_nettype wire

// File: tb/e1tbi_bp_model.sv
`timescale 1ns/1ps
`default_nettype none
module e1tbi_bp_model (
  input  wire logic i_inv,
  output logic      o_sclk,
  output logic      o_fsync,
  output logic      o_sfsync,
  output logic      o_sdata,
  output logic      o_chclk,
  output logic      o_frac
);
  logic c;
  assign o_sclk = c ^ i_inv;
  initial begin
    c = 1'b0;
    {o_fsync, o_sfsync, o_sdata, o_chclk, o_frac} = 5'h00;
  end
  // Lines move 10 ns after the launch edge, so a wrong-edge sampler sees the old bit
  task automatic send(input logic [7:0] d, input logic fs, input logic [7:0] fr);
    for (int k = 7; k >= 0; k--) begin
      c = 1'b1;
      #10;
      o_sdata = d[k];
      o_frac = fr[k];
      o_chclk = 1'b1;
      o_fsync = fs && k == 7;
      o_sfsync = fs && k == 7;
      #30 c = 1'b0;
      #40;
    end
    // Data and fractional lines show the inverse of their last value, sync and channel clock go low; clock stands still
    o_sdata = ~o_sdata;
    o_frac = ~o_frac;
    {o_fsync, o_sfsync, o_chclk} = 3'h0;
  endtask
endmodule
`default_nettype wire

// File: tb/e1tbi_chk.sv
`timescale 1ns/1ps
`default_nettype none
module e1tbi_chk (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire e1tbi_pkg::e1tbi_bus_t  i_bus,
  input  wire logic [31:0]            o_rdata,
  input  wire logic                   o_serial_clock,
  input  wire logic                   o_serial_clock_oe,
  input  wire logic [4:0]             o_tsi,
  input  wire logic [4:0]             o_tsi_oe,
  input  wire e1tbi_pkg::e1tbi_word_t o_word,
  input  wire logic                   o_word_valid,
  input  wire logic                   i_word_ready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] ctl;
  logic       drv;
  logic [4:0] oe_exp;
  // Shadow of the control and drive bits as software last wrote them
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctl <= 8'h00;
      drv <= 1'b0;
    end else if (i_bus.wr && i_bus.addr == e1tbi_pkg::REG_CTRL) begin
      ctl <= i_bus.wdata[7:0] & 8'hbf;
    end else if (i_bus.wr && i_bus.addr == e1tbi_pkg::REG_CFG) begin
      drv <= i_bus.wdata[0];
    end
  end
  assign oe_exp = (ctl[2] || ctl[1:0] != 2'h0) ? 5'h1e : (ctl[4] ? 5'h1c : 5'h1f);
  rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  ctrl_read_a: assert property ($past(i_bus.rd) && $past(i_bus.addr) == e1tbi_pkg::REG_CTRL
    |-> o_rdata == {24'h00_0000, $past(ctl)}) else $error("control readback wrong");
  pin_enable_a: assert property (ctl == $past(ctl) |-> o_tsi_oe == oe_exp)
    else $error("identifier pin enables wrong for mode");
  clk_drive_a: assert property (drv == $past(drv) |-> o_serial_clock_oe == drv)
    else $error("serial clock drive enable wrong");
  clk_quiet_a: assert property (!o_serial_clock_oe |-> !o_serial_clock)
    else $error("serial clock toggles while not driven");
  clk_half_a: assert property ($rose(o_serial_clock) |=> o_serial_clock [*8] ##[12:20] !o_serial_clock)
    else $error("serial clock high phase length wrong");
  word_hold_a: assert property (o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word))
    else $error("word changed before it was taken");
  fast_clock_a: assert property (o_tsi_oe == 5'h1c && $rose(o_tsi[2]) |=> ##[0:1] !o_tsi[2])
    else $error("fast clock pin high too long");
endmodule
bind e1tbi_top e1tbi_chk e1tbi_chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata),
  .o_serial_clock(o_serial_clock), .o_serial_clock_oe(o_serial_clock_oe), .o_tsi(o_tsi),
  .o_tsi_oe(o_tsi_oe), .o_word(o_word), .o_word_valid(o_word_valid), .i_word_ready(i_word_ready));
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic [4:0]  oe;
  } e1tbi_row_t;
  logic                   clk, rst_n, ready, sig, inv, sclk_q;
  logic                   sclk_o, sclk_oe, valid, sclk, fs, sfs, sd, chclk, frac;
  logic [31:0]            rdata, d, s;
  logic [7:0]             x;
  logic [4:0]             tsi_out, tsi_oe, tsi_pin;
  e1tbi_pkg::e1tbi_bus_t  bus;
  e1tbi_pkg::e1tbi_word_t oword, w, w2;
  int                     fails, comparisons, rises;
  e1tbi_row_t             rows [8];
  assign tsi_pin = (tsi_out & tsi_oe) | ({3'h0, frac, sig} & ~tsi_oe);
  e1tbi_bp_model e1tbi_bp_model_i (.i_inv(inv), .o_sclk(sclk), .o_fsync(fs), .o_sfsync(sfs),
    .o_sdata(sd), .o_chclk(chclk), .o_frac(frac));
  e1tbi_top e1tbi_top_i (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_bus(bus), .o_rdata(rdata),
    .i_serial_clock(sclk), .o_serial_clock(sclk_o), .o_serial_clock_oe(sclk_oe),
    .i_channel_clock(chclk), .i_frame_sync(fs), .i_superframe_sync(sfs), .i_serial_data(sd),
    .i_tsi(tsi_pin), .o_tsi(tsi_out), .o_tsi_oe(tsi_oe), .o_word(oword), .o_word_valid(valid),
    .i_word_ready(ready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    sclk_q <= sclk_o;
    if (sclk_o && !sclk_q) rises++;
  end
  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  task automatic pop(output e1tbi_pkg::e1tbi_word_t v);
    @(posedge clk);
    for (int n = 0; n < 2000 && valid !== 1'b1; n++) @(posedge clk);
    if (valid !== 1'b1) fails++;
    v = oword;
    ready <= 1'b1;
    @(posedge clk);
    ready <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    #600us;
    fails++;
    tally_and_finish();
  end
  initial begin
    bus = '0;
    {rst_n, ready, inv, sclk_q} = 4'h0;
    sig = 1'b1;
    {fails, comparisons, rises} = 0;
    rows = '{'{8'h00, 32'h0000_00ff, 32'h0000_00bf, 5'h1e}, '{8'h00, 32'h0000_0010, 32'h0000_0010, 5'h1c},
             '{8'h00, 32'h0000_0011, 32'h0000_0011, 5'h1e}, '{8'h00, 32'h0000_0004, 32'h0000_0004, 5'h1e},
             '{8'h00, 32'h0000_0000, 32'h0000_0000, 5'h1f}, '{8'h04, 32'h0000_0001, 32'h0000_0001, 5'h1f},
             '{8'h04, 32'h0000_0000, 32'h0000_0000, 5'h1f}, '{8'h0c, 32'hffff_ffff, 32'h0000_0000, 5'h1f}};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h00, d);
    check("control after reset", d, 32'h0000_0000);
    check("pin enables after reset", {27'h0, tsi_oe}, 32'h0000_001f);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      check("register readback", d, rows[i].rexp);
      check("pin enables", {27'h0, tsi_oe}, {27'h0, rows[i].oe});
    end
    e1tbi_bp_model_i.send(8'ha5, 1'b1, 8'h00);
    e1tbi_bp_model_i.send(8'h3c, 1'b0, 8'h00);
    pop(w);
    check("first slot word", {16'h0, w[15:0]}, 32'h0000_00a5);
    pop(w);
    check("second slot word", {16'h0, w[15:0]}, 32'h0000_013c);
    check("slot pins", {27'h0, tsi_out}, 32'h0000_0002);
    inv = 1'b1;
    wr(8'h00, 32'h0000_0008);
    e1tbi_bp_model_i.send(8'h96, 1'b1, 8'h00);
    pop(w);
    check("inverted edge word", {16'h0, w[15:0]}, 32'h0000_0096);
    inv = 1'b0;
    wr(8'h00, 32'h0000_000c);
    s = 32'hc3a5_5a0f;
    for (int j = 3; j >= 0; j--) e1tbi_bp_model_i.send(s[8*j+:8], j == 3, 8'h00);
    for (int c = 0; c < 4; c++) begin
      pop(w);
      for (int m = 0; m < 8; m++) x[7-m] = s[31-4*m-c];
      check("interleaved word", {16'h0, w[15:0]}, {16'h0, 1'b0, 2'(c), 5'h00, x});
    end
    wr(8'h00, 32'h0000_0090);
    e1tbi_bp_model_i.send(8'h5a, 1'b1, 8'hc6);
    pop(w);
    pop(w2);
    if (w.frac !== 1'b1) {w, w2} = {w2, w};
    check("fractional word", {16'h0, w[15:0]}, 32'h0000_81c6);
    check("data word", {15'h0, w2[16:0]}, 32'h0001_005a);
    wr(8'h00, 32'h0000_0000);
    for (int i = 0; i < 18; i++) e1tbi_bp_model_i.send(8'(i), i == 0, 8'h00);
    rd(8'h08, d);
    check("overflow flag set", {31'h0, d[9]}, 32'h0000_0001);
    for (int i = 0; i < 16; i++) begin
      pop(w);
      check("buffered word", {16'h0, w[15:0]}, {16'h0, 3'h0, 5'(i), 8'(i)});
    end
    wr(8'h08, 32'h0000_0200);
    rd(8'h08, d);
    check("overflow flag cleared", {31'h0, d[9]}, 32'h0000_0000);
    wr(8'h04, 32'h0000_0001);
    repeat (100) @(posedge clk);
    rises = 0;
    repeat (12500) @(posedge clk);
    check("continuous clock edges", {31'h0, rises inside {[253:258]}}, 32'h0000_0001);
    wr(8'h00, 32'h0000_0020);
    repeat (100) @(posedge clk);
    rises = 0;
    repeat (12500) @(posedge clk);
    check("payload clock edges", {31'h0, rises inside {[244:251]}}, 32'h0000_0001);
    while (sclk_o !== 1'b1) @(posedge clk);
    while (sclk_o !== 1'b0) @(posedge clk);
    wr(8'h04, 32'h0000_0000);
    repeat (4) @(posedge clk);
    check("clock pin released", {31'h0, sclk_oe}, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
